// ### rtl/drive_state_status.v
// Drive state report word and quick-stop / shutdown reaction selectors.
// Assumes the state machine, motion and power logic around it supply live
// conditions as inputs, and an object access port writes/reads by index.
//
// Operation
// - Report word is live, nothing latched
// - Encode power-stage state in bits 0-3,5,6
// - Bit 4 follows high voltage present
// - Bit 5 low during quick stop
// - Quick stop: bits 0-2 set, fault optional
// - Bit 7 on any warning threshold
// - Bit 8 always zero
// - Bit 9 always one, remote
// - Bits 14 and 15 always zero
// - Bit 10 target reached, updates on change
// - Selector 5/6: target set after quick stop
// - Halt standstill sets target reached
// - Limit or stop switch clears target
// - Bit 11 on any internal limit
// - Bits 12-13 mode dependent
// - Quick stop on request or comm error
// - Selector 1/2: ramp, then switch-on-disabled
// - Selector 5/6: ramp, stay quick stop
// - Bad quick-stop value aborted, kept
// - Shutdown selector 0 disable, 1 ramp
// - Bad shutdown value aborted
`include "drive_state_defs.vh"
`default_nettype none

module drive_state_status
(
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    // Live drive conditions
    input wire [2:0] power_state,
    input wire fault_in_quick_stop,
    input wire high_voltage_on,
    input wire warn_temperature,
    input wire warn_over_voltage,
    input wire warn_under_voltage,
    input wire warn_encoder_amplitude,
    input wire warn_end_at_encoder,
    input wire setpoint_reached,
    input wire target_changed,
    input wire quick_stop_done,
    input wire halt_standstill,
    input wire sw_position_limit,
    input wire forward_limit_switch,
    input wire reverse_limit_switch,
    input wire stop_switch,
    input wire [1:0] mode_specific_bits,
    // Quick stop and shutdown triggers
    input wire quick_stop_request,
    input wire comm_error_quick_stop,
    input wire shutdown_request,
    // Object access port
    input wire obj_wr,
    input wire obj_rd,
    input wire [15:0] obj_index,
    input wire [15:0] obj_wdata,
    output reg [15:0] obj_rdata,
    output reg obj_ack,
    output reg obj_abort,
    output reg [31:0] obj_abort_code,
    // Stop reaction commands to motion logic, and the report word
    output reg quick_stop_active,
    output reg [1:0] quick_stop_action,
    output reg quick_stop_to_disabled,
    output reg [1:0] shutdown_action,
    output reg shutdown_active,
    output wire [15:0] drive_state_report
);

    // ----------------------------------------
    // Selector validity functions
    // ----------------------------------------

    // Quick-stop selector supports 1, 2, 5 and 6 only
    function qs_valid;
        input [15:0] v;
        begin
            qs_valid = (v == 16'h0001) || (v == 16'h0002) || (v == 16'h0005) || (v == 16'h0006);
        end
    endfunction

    // Shutdown selector supports 0 and 1 only
    function sd_valid;
        input [15:0] v;
        begin
            sd_valid = (v == 16'h0000) || (v == 16'h0001);
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [15:0] quick_stop_reaction_select_q; // Quick-stop selector
    reg [15:0] shutdown_reaction_select_q; // Shutdown selector
    reg target_reached_q; // Target reached flag
    reg [15:0] report_d; // Combinational report word

    // ----------------------------------------
    // Report word assembly
    // ----------------------------------------

    // Built from live inputs plus the registered target flag so nothing latches
    always @*
    begin
        report_d = 16'h0000; // Reserved bits stay zero
        case (power_state)
            `ST_NOT_READY:
            begin
                report_d[3:0] = 4'h0;
            end
            `ST_SW_ON_DISABLED:
            begin
                report_d[`RPT_SWITCH_ON_DIS] = 1'b1;
            end
            `ST_READY:
            begin
                report_d[3:0] = 4'h1;
                report_d[`RPT_QUICK_STOP_N] = 1'b1;
            end
            `ST_SWITCHED_ON:
            begin
                report_d[3:0] = 4'h3;
                report_d[`RPT_QUICK_STOP_N] = 1'b1;
            end
            `ST_OP_ENABLED:
            begin
                report_d[3:0] = 4'h7;
                report_d[`RPT_QUICK_STOP_N] = 1'b1;
            end
            `ST_QUICK_STOP:
            begin
                // Bit 5 low, bits 0-2 high
                report_d[3:0] = {fault_in_quick_stop, 3'h7};
            end
            `ST_FAULT_REACTION:
            begin
                report_d[3:0] = 4'hF;
            end
            default:
            begin
                report_d[3:0] = 4'h8; // Fault
            end
        endcase
        report_d[`RPT_VOLTAGE] = high_voltage_on;
        report_d[`RPT_WARNING] = warn_temperature | warn_over_voltage | warn_under_voltage
            | warn_encoder_amplitude | warn_end_at_encoder;
        report_d[`RPT_REMOTE] = 1'b1; // Remote always
        report_d[`RPT_TARGET] = target_reached_q;
        report_d[`RPT_INT_LIMIT] = sw_position_limit | forward_limit_switch
            | reverse_limit_switch | stop_switch;
        report_d[`RPT_MODE_HI:`RPT_MODE_LO] = mode_specific_bits;
    end

    // Live view, no capture register
    assign drive_state_report = report_d;

    // ----------------------------------------
    // Target reached tracking
    // ----------------------------------------

    // Switch stops win: an axis on a limit or stop switch never reports target; sw_position_limit does not clear it
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            target_reached_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (forward_limit_switch || reverse_limit_switch || stop_switch)
            begin
                target_reached_q <= 1'b0;
            end
            else if (halt_standstill)
            begin
                target_reached_q <= 1'b1;
            end
            else if (quick_stop_done && power_state == `ST_QUICK_STOP
                && quick_stop_reaction_select_q[2])
            begin
                target_reached_q <= 1'b1; // Selector 5 or 6
            end
            else if (target_changed)
            begin
                target_reached_q <= 1'b0; // New target restarts
            end
            else
            begin
                target_reached_q <= setpoint_reached;
            end
        end
    end

    // ----------------------------------------
    // Object access: selector writes and reads
    // ----------------------------------------

    // One-cycle ack or abort per access; rejected writes leave value unchanged
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            quick_stop_reaction_select_q <= `QS_SEL_RESET;
            shutdown_reaction_select_q <= `SD_SEL_RESET;
            obj_rdata <= 16'h0000;
            obj_ack <= 1'b0;
            obj_abort <= 1'b0;
            obj_abort_code <= 32'h00000000;
        end
        else if (clk_en)
        begin
            obj_ack <= 1'b0;
            obj_abort <= 1'b0;
            if (obj_wr)
            begin
                if (obj_index == `IDX_QUICK_STOP_SELECT)
                begin
                    if (qs_valid(obj_wdata))
                    begin
                        quick_stop_reaction_select_q <= obj_wdata;
                        obj_ack <= 1'b1;
                    end
                    else
                    begin
                        obj_abort <= 1'b1;
                        obj_abort_code <= `ABORT_VALUE_EXCEEDED;
                    end
                end
                else if (obj_index == `IDX_SHUTDOWN_SELECT)
                begin
                    if (sd_valid(obj_wdata))
                    begin
                        shutdown_reaction_select_q <= obj_wdata;
                        obj_ack <= 1'b1;
                    end
                    else
                    begin
                        obj_abort <= 1'b1;
                        obj_abort_code <= `ABORT_VALUE_EXCEEDED;
                    end
                end
                else
                begin
                    // Report is read only; unknown index also aborts
                    obj_abort <= 1'b1;
                    obj_abort_code <= `ABORT_VALUE_EXCEEDED;
                end
            end
            else if (obj_rd)
            begin
                if (obj_index == `IDX_DRIVE_STATE_REPORT)
                begin
                    obj_rdata <= report_d;
                    obj_ack <= 1'b1;
                end
                else if (obj_index == `IDX_QUICK_STOP_SELECT)
                begin
                    obj_rdata <= quick_stop_reaction_select_q;
                    obj_ack <= 1'b1;
                end
                else if (obj_index == `IDX_SHUTDOWN_SELECT)
                begin
                    obj_rdata <= shutdown_reaction_select_q;
                    obj_ack <= 1'b1;
                end
                else
                begin
                    obj_rdata <= 16'h0000;
                    obj_abort <= 1'b1;
                    obj_abort_code <= `ABORT_VALUE_EXCEEDED;
                end
            end
        end
    end

    // ----------------------------------------
    // Stop reaction commands
    // ----------------------------------------

    // Registered so motion logic sees a clean action per cycle
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            quick_stop_active <= 1'b0;
            quick_stop_action <= `ACT_NONE;
            quick_stop_to_disabled <= 1'b0;
            shutdown_active <= 1'b0;
            shutdown_action <= `ACT_NONE;
        end
        else if (clk_en)
        begin
            // Either trigger from operation enabled
            quick_stop_active <= (quick_stop_request || comm_error_quick_stop)
                && power_state == `ST_OP_ENABLED;
            // Ramp choice: odd selector slow ramp, even quick ramp
            quick_stop_action <= quick_stop_reaction_select_q[0] ? `ACT_SLOW_RAMP : `ACT_QS_RAMP;
            // Selector 1/2 exits to disabled, 5/6 stays
            quick_stop_to_disabled <= ~quick_stop_reaction_select_q[2];
            shutdown_active <= shutdown_request && power_state == `ST_OP_ENABLED;
            shutdown_action <= shutdown_reaction_select_q[0] ? `ACT_SLOW_RAMP : `ACT_DISABLE;
        end
    end

endmodule // drive_state_status

`default_nettype wire

// ### rtl/drive_state_defs.vh
// Constants for the drive state report and stop-reaction selector block.
// Assumes inclusion by bare name from rtl files; definitions only.
`ifndef DRIVE_STATE_DEFS_VH
`define DRIVE_STATE_DEFS_VH

// ----------------------------------------
// Object dictionary indexes
// ----------------------------------------
`define IDX_DRIVE_STATE_REPORT 16'h6041
`define IDX_QUICK_STOP_SELECT 16'h605A
`define IDX_SHUTDOWN_SELECT 16'h605B

// ----------------------------------------
// Report word bit positions
// ----------------------------------------
`define RPT_READY 0
`define RPT_SWITCHED_ON 1
`define RPT_OP_ENABLED 2
`define RPT_FAULT 3
`define RPT_VOLTAGE 4
`define RPT_QUICK_STOP_N 5
`define RPT_SWITCH_ON_DIS 6
`define RPT_WARNING 7
`define RPT_RESERVED8 8
`define RPT_REMOTE 9
`define RPT_TARGET 10
`define RPT_INT_LIMIT 11
`define RPT_MODE_LO 12
`define RPT_MODE_HI 13

// ----------------------------------------
// Reset values and abort code
// ----------------------------------------
`define QS_SEL_RESET 16'h0002
`define SD_SEL_RESET 16'h0000
`define ABORT_VALUE_EXCEEDED 32'h06090030

// ----------------------------------------
// Power-stage state codes
// ----------------------------------------
`define ST_NOT_READY 3'h0
`define ST_SW_ON_DISABLED 3'h1
`define ST_READY 3'h2
`define ST_SWITCHED_ON 3'h3
`define ST_OP_ENABLED 3'h4
`define ST_QUICK_STOP 3'h5
`define ST_FAULT_REACTION 3'h6
`define ST_FAULT 3'h7

// ----------------------------------------
// Stop reaction actions
// ----------------------------------------
`define ACT_NONE 2'h0
`define ACT_DISABLE 2'h1
`define ACT_SLOW_RAMP 2'h2
`define ACT_QS_RAMP 2'h3

`endif

// ### sim/od_master.sv
// Network master model driving the object access port.
// Assumes ack or abort is registered on the taking edge and read half a cycle later.
`default_nettype none
module od_master
(
    input wire logic ref_clk,
    output logic obj_wr = 1'b0,
    output logic obj_rd = 1'b0,
    output logic [15:0] obj_index = 16'h0000,
    output logic [15:0] obj_wdata = 16'h0000,
    input wire logic [15:0] obj_rdata,
    input wire logic obj_ack,
    input wire logic obj_abort
);
    timeunit 1ns;
    timeprecision 1ns;
    // One request for one cycle; released data shows its inverse
    task access(input logic w, input logic [15:0] i, input logic [15:0] d,
        output logic [1:0] r, output logic [15:0] q);
    begin
        @(negedge ref_clk);
        obj_wr = w;
        obj_rd = !w;
        obj_index = i;
        obj_wdata = d;
        @(negedge ref_clk);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_wdata = ~d;
        r = {obj_abort, obj_ack};
        q = obj_rdata;
    end
    endtask
endmodule // od_master
`default_nettype wire

// ### sim/dss_checker_assertions.sv
// Port checker for drive_state_status.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module dss_checker
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [2:0] power_state,
    input wire logic fault_in_quick_stop,
    input wire logic high_voltage_on,
    input wire logic [1:0] mode_specific_bits,
    input wire logic quick_stop_request,
    input wire logic comm_error_quick_stop,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [15:0] obj_wdata,
    input wire logic obj_ack,
    input wire logic obj_abort,
    input wire logic [31:0] obj_abort_code,
    input wire logic quick_stop_active,
    input wire logic [15:0] drive_state_report
);
    // ---
    // Report word, selector port and quick-stop start
    // ---
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_fixed_bits:
        assert property ({drive_state_report[15:14], drive_state_report[9:8]} == 4'h2)
        else $error("fixed bits wrong");
    a_voltage_bit: assert property (drive_state_report[4] == high_voltage_on)
        else $error("voltage bit wrong");
    a_mode_bits: assert property (drive_state_report[13:12] == mode_specific_bits)
        else $error("mode bits wrong");
    a_quick_stop_code:
        assert property (power_state == 3'h5 |->
            {drive_state_report[6:5], drive_state_report[3:0]} == {2'h0, fault_in_quick_stop, 3'h7})
        else $error("quick stop code wrong");
    a_quick_stop_go:
        assert property (clk_en && (quick_stop_request || comm_error_quick_stop) && power_state == 3'h4
            |=> quick_stop_active)
        else $error("quick stop not started");
    a_write_answer: assert property (clk_en && obj_wr |=> obj_ack != obj_abort)
        else $error("write answer wrong");
    a_bad_quick_stop:
        assert property (clk_en && obj_wr && obj_index == 16'h605A
            && !(obj_wdata inside {16'h1, 16'h2, 16'h5, 16'h6}) |=> obj_abort && obj_abort_code == 32'h06090030)
        else $error("bad quick stop value taken");
    a_bad_shutdown:
        assert property (clk_en && obj_wr && obj_index == 16'h605B && obj_wdata > 16'h1
            |=> obj_abort && obj_abort_code == 32'h06090030)
        else $error("bad shutdown value taken");
    c_quick_stop: cover property (quick_stop_active);
    c_abort: cover property (obj_abort);
    c_target_in_qs: cover property (power_state == 3'h5 && drive_state_report[10]);
endmodule // dss_checker
bind drive_state_status dss_checker i_dss_checker (.*);
`default_nettype wire

// ### sim/drive_state_status_test.sv
// Bench for drive_state_status with a master model on the object port.
// Assumes od_master and dss_checker compile first.
`default_nettype none
module drive_state_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_n, clk_en, fault_in_quick_stop, high_voltage_on, sw_position_limit;
    logic warn_temperature, warn_over_voltage, warn_under_voltage, warn_encoder_amplitude, warn_end_at_encoder;
    logic setpoint_reached, target_changed, quick_stop_done, halt_standstill, stop_switch, shutdown_request;
    logic forward_limit_switch, reverse_limit_switch, quick_stop_request, comm_error_quick_stop;
    logic quick_stop_active, quick_stop_to_disabled, shutdown_active;
    logic [2:0] power_state;
    logic [1:0] mode_specific_bits, quick_stop_action, shutdown_action, r;
    wire obj_wr, obj_rd, obj_ack, obj_abort;
    wire [15:0] obj_index, obj_wdata, obj_rdata, drive_state_report;
    wire [31:0] obj_abort_code;
    logic [15:0] q;
    int checked = 0, mismatches = 0;
    drive_state_status i_drive_state_status (.*);
    od_master i_od_master (.*);
    // 10 MHz clock
    initial forever #50 ref_clk = ~ref_clk;
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    begin
        checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    end
    endtask
    task acc(input logic w, input logic [15:0] i, input logic [15:0] d);
        i_od_master.access(w, i, d, r, q);
    endtask
    // Each state code read over the port, live flags walked alongside
    task t_state;
        logic [6:0] v [8];
        logic [6:0] m;
    begin
        v = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h0F, 7'h0F, 7'h08};
        acc(1'b0, 16'h605A, 16'h0);
        chk("qs_sel", 16'h2, q);
        acc(1'b0, 16'h605B, 16'h0);
        chk("sd_sel", 16'h0, q);
        for (int s = 0; s < 8; s++)
        begin
            power_state = s[2:0];
            high_voltage_on = s[0];
            mode_specific_bits = s[1:0];
            {warn_temperature, warn_over_voltage, warn_under_voltage, warn_encoder_amplitude,
                warn_end_at_encoder} = 5'h01 << s;
            {sw_position_limit, forward_limit_switch, reverse_limit_switch, stop_switch} = 4'h1 << s;
            // Bit 4 is left to the flags check; bit 5 is masked outside states 2 to 5
            m = (s < 2 || s > 5) ? 7'h4F : 7'h6F;
            acc(1'b0, 16'h6041, 16'h0);
            chk("state", {9'h0, v[s] & m}, {9'h0, q[6:0] & m});
            chk("flags", {2'h0, s[1:0], s < 4, 3'h2, s < 5, 2'h0, s[0], 4'h0}, q & 16'hFB90);
        end
    end
    endtask
    // Good quick-stop choices, each followed by a bad one that must bounce
    task t_qs;
        logic [15:0] v [4];
        logic [15:0] b [4];
    begin
        v = '{16'h1, 16'h2, 16'h5, 16'h6};
        b = '{16'h0, 16'h3, 16'h4, 16'h7};
        for (int k = 0; k < 4; k++)
        begin
            acc(1'b1, 16'h605A, v[k]);
            chk("qs_wr", 16'h1, {14'h0, r});
            acc(1'b1, 16'h605A, b[k]);
            chk("qs_bad", 16'h2, {14'h0, r});
            acc(1'b0, 16'h605A, 16'h0);
            chk("qs_rd", v[k], q);
            power_state = 3'h4;
            quick_stop_request = k[0];
            comm_error_quick_stop = !k[0];
            @(negedge ref_clk);
            chk("qs_out", {12'h0, 1'b1, v[k][0] ? 2'h2 : 2'h3, v[k] < 3},
                {12'h0, quick_stop_active, quick_stop_action, quick_stop_to_disabled});
            quick_stop_request = 1'b0;
            comm_error_quick_stop = 1'b0;
        end
    end
    endtask
    // Both shutdown choices, then a bad value or a read-only write
    task t_sd;
    begin
        for (int k = 0; k < 2; k++)
        begin
            acc(1'b1, 16'h605B, k[15:0]);
            chk("sd_wr", 16'h1, {14'h0, r});
            shutdown_request = 1'b1;
            @(negedge ref_clk);
            chk("sd_out", {13'h0, 1'b1, k[0] ? 2'h2 : 2'h1}, {13'h0, shutdown_active, shutdown_action});
            shutdown_request = 1'b0;
            acc(1'b1, k[0] ? 16'h6041 : 16'h605B, 16'h2);
            chk("sd_bad", 16'h2, {14'h0, r});
            acc(1'b0, 16'h605B, 16'h0);
            chk("sd_rd", k[15:0], q);
        end
    end
    endtask
    task tgt(input logic [4:0] c, input logic e);
    begin
        @(negedge ref_clk);
        {setpoint_reached, target_changed, quick_stop_done, halt_standstill, stop_switch} = c;
        @(negedge ref_clk);
        chk("target", {15'h0, e}, {15'h0, drive_state_report[10]});
    end
    endtask
    // Target flag sources, two with an override on top; selector left at 6
    task t_target;
    begin
        tgt(5'b10000, 1'b1);
        tgt(5'b11000, 1'b0);
        tgt(5'b00010, 1'b1);
        tgt(5'b00011, 1'b0);
        power_state = 3'h5;
        tgt(5'b00100, 1'b1);
    end
    endtask
    task test_done;
    begin
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // Run takes some 90 cycles, so 2000 means a hang
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        mismatches++;
        test_done;
    end
    initial
    begin
        {power_state, high_voltage_on, sw_position_limit, warn_temperature, warn_over_voltage, warn_under_voltage,
            warn_encoder_amplitude, warn_end_at_encoder, setpoint_reached, target_changed, quick_stop_done,
            halt_standstill, stop_switch, shutdown_request, forward_limit_switch, reverse_limit_switch,
            quick_stop_request, comm_error_quick_stop, mode_specific_bits} = '0;
        clk_en = 1'b1;
        fault_in_quick_stop = 1'b1;
        rst_n = 1'b0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        t_state;
        t_qs;
        t_sd;
        t_target;
        test_done;
    end
endmodule // drive_state_status_test
`default_nettype wire
